// >>> hw/fsc_pkg.sv
// Shared constants for the flash erase and program control block
package fsc_pkg;

  // ---------------------------------------------------------------
  // Special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_ERASE_COMMAND = 8'h94;
  localparam logic [7:0] SFR_PERMIT        = 8'hb2;
  localparam logic [7:0] SFR_PAGE_SELECT   = 8'hb7;

  // ---------------------------------------------------------------
  // Command patterns and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] PAT_PAGE_ERASE    = 8'h55;
  localparam logic [7:0] PAT_MASS_ERASE    = 8'haa;
  localparam int         BIT_STORE_PERMIT  = 0;
  localparam int         BIT_MASS_PERMIT   = 1;
  localparam int         PAGE_LSB          = 1;
  localparam int         PAGE_W            = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]        RST_ERASE_COMMAND = 8'h00;
  localparam logic              RST_MASS_PERMIT   = 1'h0;
  localparam logic              RST_STORE_PERMIT  = 1'h0;
  localparam logic [PAGE_W-1:0] RST_PAGE_SELECT   = 7'h00;

  // ---------------------------------------------------------------
  // Erase durations in cycles
  // ---------------------------------------------------------------
  localparam int PAGE_ERASE_CYCLES = 2000;
  localparam int MASS_ERASE_CYCLES = 4000;
  localparam int TIMER_W           = 16;

  // ---------------------------------------------------------------
  // Controller APB register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] APB_CTRL      = 8'h00;
  localparam logic [7:0] APB_SFR_WRITE = 8'h04;
  localparam logic [7:0] APB_STORE     = 8'h08;
  localparam logic [7:0] APB_SFR_READ  = 8'h0c;
  localparam logic [7:0] APB_STATUS    = 8'h10;
  localparam int         CTRL_IRQ_EN   = 0;
  localparam int         CTRL_DEBUG_EN = 1;

endpackage : fsc_pkg

// >>> hw/fsc_sfr_if.sv
// Special function register and store bus between core and flash control
`timescale 1ns/1ps
interface fsc_sfr_if;
  logic        sfr_we;
  logic        sfr_re;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        store_we;
  logic [15:0] store_addr;
  logic [7:0]  store_data;
  logic        irq_global_en;
  logic        debug_port_en;
  logic        erase_busy;

  modport core
  (
    output sfr_we, sfr_re, sfr_addr, sfr_wdata, store_we, store_addr, store_data,
    output irq_global_en, debug_port_en,
    input  sfr_rdata, erase_busy
  );

  modport dev
  (
    input  sfr_we, sfr_re, sfr_addr, sfr_wdata, store_we, store_addr, store_data,
    input  irq_global_en, debug_port_en,
    output sfr_rdata, erase_busy
  );
endinterface : fsc_sfr_if

// >>> hw/fsc_cycle_timer.sv
// Down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ps
module fsc_cycle_timer #(
  parameter int W = 16
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic [W-1:0] cycles,
  output logic              busy
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         busy;
  } fsc_timer_st_t;

  fsc_timer_st_t q;
  fsc_timer_st_t d;

  if (W < 2)
  begin : g_chk
    $error("fsc_cycle_timer: W must be at least 2");
  end

  // ---------------------------------------------------------------
  // Count
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (start)
    begin
      d.count = cycles;
      d.busy  = (cycles != '0);
    end
    else if (q.busy)
    begin
      d.count = q.count - W'(1);
      d.busy  = (q.count > W'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign busy = q.busy;

endmodule : fsc_cycle_timer

// >>> hw/fsc_flash_ctrl.sv
// Flash erase and program control, device end of the register bus
`timescale 1ns/1ps
// Overview of operation
// - Page pattern starts erase of selected page
// - Mass pattern starts whole array erase
// - Other command values change nothing
// - Core writes page select before page erase
// - Mass erase needs permit and debug port
// - Mass permit resets to zero
// - Mass permit serves one mass erase
// - Page select seven bits, pages 0..127
// - Page select serves one page erase
// - Permit clear: stores go to data RAM
// - Permit set: store writes flash byte, store dropped while erase runs
// - Store permit self clears after flash byte
// - Store permit writes ignored while interrupts enabled
module fsc_flash_ctrl #(
  parameter int PAGE_CYCLES = fsc_pkg::PAGE_ERASE_CYCLES,
  parameter int MASS_CYCLES = fsc_pkg::MASS_ERASE_CYCLES
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  fsc_sfr_if.dev                         bus,
  output logic                           flash_wr,
  output logic [15:0]                    flash_addr,
  output logic [7:0]                     flash_data,
  output logic                           external_data_ram_wr,
  output logic [15:0]                    external_data_ram_addr,
  output logic [7:0]                     external_data_ram_data,
  output logic                           page_erase_start,
  output logic                           mass_erase_start,
  output logic [fsc_pkg::PAGE_W-1:0]     erase_page
);

  typedef struct packed {
    logic                       mass_permit;
    logic                       store_permit;
    logic [fsc_pkg::PAGE_W-1:0] page_sel;
    logic                       page_fresh;
    logic                       start_page;
    logic                       start_mass;
    logic [fsc_pkg::PAGE_W-1:0] erase_page;
    logic                       busy;
    logic [7:0]                 rdata;
    logic                       flash_wr;
    logic [15:0]                flash_addr;
    logic [7:0]                 flash_data;
    logic                       external_data_ram_wr;
    logic [15:0]                external_data_ram_addr;
    logic [7:0]                 external_data_ram_data;
  } fsc_dev_st_t;

  localparam int TW = fsc_pkg::TIMER_W;

  fsc_dev_st_t q;
  fsc_dev_st_t d;
  logic        t_busy;
  logic        erasing;
  logic [TW-1:0] t_cycles;
  logic          page_ok;
  logic          mass_ok;
  logic          start_any;
  logic          rd_permit;

  if (PAGE_CYCLES < 1 || MASS_CYCLES < 1 || PAGE_CYCLES >= (1 << TW) ||
      MASS_CYCLES >= (1 << TW))
  begin : g_chk
    $error("fsc_flash_ctrl: erase cycle counts out of range");
  end

  if (fsc_pkg::PAGE_LSB + fsc_pkg::PAGE_W > 8)
  begin : g_chk_field
    $error("fsc_flash_ctrl: page field does not fit its register");
  end

  if (fsc_pkg::PAT_PAGE_ERASE == fsc_pkg::PAT_MASS_ERASE)
  begin : g_chk_pat
    $error("fsc_flash_ctrl: erase patterns must differ");
  end

  // ---------------------------------------------------------------
  // Erase timer
  // ---------------------------------------------------------------
  assign start_any = q.start_page | q.start_mass;
  assign t_cycles  = q.start_mass ? TW'(MASS_CYCLES) : TW'(PAGE_CYCLES);
  assign erasing   = q.busy | t_busy | start_any;

  fsc_cycle_timer #(
    .W       (TW)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_any),
    .cycles  (t_cycles),
    .busy    (t_busy)
  );

  // ---------------------------------------------------------------
  // Command qualification
  // ---------------------------------------------------------------
  assign page_ok   = (bus.sfr_wdata == fsc_pkg::PAT_PAGE_ERASE) && q.page_fresh;
  assign mass_ok   = (bus.sfr_wdata == fsc_pkg::PAT_MASS_ERASE) && q.mass_permit &&
                     bus.debug_port_en;
  assign rd_permit = bus.sfr_re && (bus.sfr_addr == fsc_pkg::SFR_PERMIT);

  // ---------------------------------------------------------------
  // Register writes, commands and stores
  // ---------------------------------------------------------------
  always_comb
  begin
    d            = q;
    d.start_page = 1'b0;
    d.start_mass = 1'b0;
    d.flash_wr   = 1'b0;
    d.external_data_ram_wr    = 1'b0;
    d.rdata      = 8'h00;
    if (bus.sfr_we)
    begin
      unique case (bus.sfr_addr)
        fsc_pkg::SFR_ERASE_COMMAND:
        begin
          if (!erasing)
          begin
            if (page_ok)
            begin
              d.start_page = 1'b1;
              d.erase_page = q.page_sel;
              d.page_fresh = 1'b0;
            end
            else if (mass_ok)
            begin
              d.start_mass  = 1'b1;
              d.mass_permit = 1'b0;
            end
            // Any other value falls through untouched
          end
        end
        fsc_pkg::SFR_PAGE_SELECT:
        begin
          d.page_sel   = bus.sfr_wdata[fsc_pkg::PAGE_LSB +: fsc_pkg::PAGE_W];
          d.page_fresh = 1'b1;
        end
        fsc_pkg::SFR_PERMIT:
        begin
          d.mass_permit = bus.sfr_wdata[fsc_pkg::BIT_MASS_PERMIT];
          if (!bus.irq_global_en)
            d.store_permit = bus.sfr_wdata[fsc_pkg::BIT_STORE_PERMIT];
        end
        default:
        begin
        end
      endcase
    end
    if (bus.store_we)
    begin
      if (q.store_permit)
      begin
        if (!erasing)
        begin
          d.flash_wr     = 1'b1;
          d.flash_addr   = bus.store_addr;
          d.flash_data   = bus.store_data;
          d.store_permit = 1'b0;
        end
      end
      else
      begin
        d.external_data_ram_wr   = 1'b1;
        d.external_data_ram_addr = bus.store_addr;
        d.external_data_ram_data = bus.store_data;
      end
    end
    if (rd_permit)
      d.rdata[fsc_pkg::BIT_STORE_PERMIT] = q.store_permit;
    d.busy = t_busy | d.start_page | d.start_mass | start_any;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q              <= '0;
      q.mass_permit  <= fsc_pkg::RST_MASS_PERMIT;
      q.store_permit <= fsc_pkg::RST_STORE_PERMIT;
      q.page_sel     <= fsc_pkg::RST_PAGE_SELECT;
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.sfr_rdata    = q.rdata;
  assign bus.erase_busy   = q.busy;
  assign flash_wr         = q.flash_wr;
  assign flash_addr       = q.flash_addr;
  assign flash_data       = q.flash_data;
  assign external_data_ram_wr          = q.external_data_ram_wr;
  assign external_data_ram_addr        = q.external_data_ram_addr;
  assign external_data_ram_data        = q.external_data_ram_data;
  assign page_erase_start = q.start_page;
  assign mass_erase_start = q.start_mass;
  assign erase_page       = q.erase_page;

endmodule : fsc_flash_ctrl

// >>> hw/fsc_core_ctrl.sv
// Core end: APB slave that issues register writes, reads and stores
`timescale 1ns/1ps
module fsc_core_ctrl
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  fsc_sfr_if.core          bus
);

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        sfr_we;
    logic        sfr_re;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        store_we;
    logic [15:0] store_addr;
    logic [7:0]  store_data;
    logic        irq_en;
    logic        debug_en;
    logic        rd_pend;
    logic        rd_wait;
    logic        rd_valid;
    logic [7:0]  rd_data;
  } fsc_core_st_t;

  fsc_core_st_t q;
  fsc_core_st_t d;
  logic         mapped;
  logic         done;

  assign mapped = (paddr == fsc_pkg::APB_CTRL) || (paddr == fsc_pkg::APB_SFR_WRITE) ||
                  (paddr == fsc_pkg::APB_STORE) || (paddr == fsc_pkg::APB_SFR_READ) ||
                  (paddr == fsc_pkg::APB_STATUS);
  assign done   = psel && penable && q.pready;

  // ---------------------------------------------------------------
  // APB handling, one wait state per access
  // ---------------------------------------------------------------
  always_comb
  begin
    d          = q;
    d.sfr_we   = 1'b0;
    d.sfr_re   = 1'b0;
    d.store_we = 1'b0;
    d.pready   = 1'b0;
    d.pslverr  = 1'b0;
    if (q.rd_wait)
    begin
      d.rd_wait  = 1'b0;
      d.rd_valid = 1'b1;
      d.rd_data  = bus.sfr_rdata;
    end
    if (q.rd_pend)
    begin
      d.rd_pend = 1'b0;
      d.rd_wait = 1'b1;
    end
    if (psel && penable && !q.pready)
    begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          fsc_pkg::APB_CTRL:
          begin
            d.prdata[fsc_pkg::CTRL_IRQ_EN]   = q.irq_en;
            d.prdata[fsc_pkg::CTRL_DEBUG_EN] = q.debug_en;
          end
          fsc_pkg::APB_SFR_READ:
          begin
            d.prdata[7:0] = q.rd_data;
            d.prdata[31]  = q.rd_valid;
          end
          fsc_pkg::APB_STATUS:
            d.prdata[0] = bus.erase_busy;
          default:
          begin
          end
        endcase
      end
    end
    if (done && pwrite)
    begin
      unique case (paddr)
        fsc_pkg::APB_CTRL:
        begin
          d.irq_en   = pwdata[fsc_pkg::CTRL_IRQ_EN];
          d.debug_en = pwdata[fsc_pkg::CTRL_DEBUG_EN];
        end
        fsc_pkg::APB_SFR_WRITE:
        begin
          d.sfr_we    = 1'b1;
          d.sfr_addr  = pwdata[15:8];
          d.sfr_wdata = pwdata[7:0];
        end
        fsc_pkg::APB_STORE:
        begin
          d.store_we   = 1'b1;
          d.store_addr = pwdata[23:8];
          d.store_data = pwdata[7:0];
        end
        fsc_pkg::APB_SFR_READ:
        begin
          d.sfr_re   = 1'b1;
          d.sfr_addr = pwdata[15:8];
          d.rd_pend  = 1'b1;
          d.rd_valid = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign bus.sfr_we        = q.sfr_we;
  assign bus.sfr_re        = q.sfr_re;
  assign bus.sfr_addr      = q.sfr_addr;
  assign bus.sfr_wdata     = q.sfr_wdata;
  assign bus.store_we      = q.store_we;
  assign bus.store_addr    = q.store_addr;
  assign bus.store_data    = q.store_data;
  assign bus.irq_global_en = q.irq_en;
  assign bus.debug_port_en = q.debug_en;

endmodule : fsc_core_ctrl

// >>> bench/fsc_flash_ctrl_checker.sv
// Assertions on the register bus between core and flash control
`timescale 1ns/1ps
module fsc_flash_ctrl_checker
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       sfr_we,
  input wire logic       sfr_re,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       debug_port_en,
  input wire logic       erase_busy
);
  // ---------------------------------------------------------------
  // Command decode and permit tracking
  // ---------------------------------------------------------------
  logic cmd, pg_cmd, me_cmd, bad_cmd, pg_q, me_q;
  assign cmd     = sfr_we && sfr_addr == fsc_pkg::SFR_ERASE_COMMAND && !erase_busy;
  assign pg_cmd  = cmd && sfr_wdata == fsc_pkg::PAT_PAGE_ERASE;
  assign me_cmd  = cmd && sfr_wdata == fsc_pkg::PAT_MASS_ERASE;
  assign bad_cmd = cmd && !pg_cmd && !me_cmd;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pg_q <= 1'b0;
      me_q <= 1'b0;
    end
    else
    begin
      if (sfr_we && sfr_addr == fsc_pkg::SFR_PAGE_SELECT) pg_q <= 1'b1;
      else if (pg_cmd && pg_q) pg_q <= 1'b0;
      if (sfr_we && sfr_addr == fsc_pkg::SFR_PERMIT) me_q <= sfr_wdata[1];
      else if (me_cmd && debug_port_en) me_q <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_busy_run;
    erase_busy [*8];
  endsequence
  sequence s_busy_done;
    ##[1:40] !erase_busy;
  endsequence
  AST_PAGE_START: assert property (pg_cmd && pg_q |=> erase_busy)
    else $error("page erase did not start");
  AST_MASS_START: assert property (me_cmd && me_q && debug_port_en |=> erase_busy)
    else $error("mass erase did not start");
  AST_BAD_PATTERN: assert property (bad_cmd |=> !erase_busy)
    else $error("other pattern started an erase");
  AST_MASS_GATED: assert property (me_cmd && !(me_q && debug_port_en) |=> !erase_busy)
    else $error("mass erase started without permit");
  AST_PAGE_GATED: assert property (pg_cmd && !pg_q |=> !erase_busy)
    else $error("page erase started without fresh select");
  AST_BUSY_HOLD: assert property ($rose(erase_busy) |-> s_busy_run)
    else $error("erase busy dropped early");
  AST_BUSY_END: assert property ($rose(erase_busy) |-> s_busy_done)
    else $error("erase busy never ended");
  AST_PERMIT_READ: assert property (sfr_re && sfr_addr == fsc_pkg::SFR_PERMIT
    |=> sfr_rdata[7:1] == 7'h00)
    else $error("mass permit visible on read");
endmodule : fsc_flash_ctrl_checker

// >>> bench/fsc_flash_ctrl_bench.sv
// Testbench joining core and flash control ends over the register bus
`timescale 1ns/1ps
module fsc_flash_ctrl_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, flash_data, external_data_ram_data;
  logic [31:0] pwdata, prdata, rd;
  logic        flash_wr, external_data_ram_wr, pg_go, me_go;
  logic [15:0] flash_addr, external_data_ram_addr;
  logic [6:0]  erase_page;
  int          num_errors, total_checks, n_pg, n_me, n_fl, n_xr;
  fsc_sfr_if sfr ();
  fsc_core_ctrl u_fsc_core_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(sfr.core));
  fsc_flash_ctrl #(.PAGE_CYCLES(20), .MASS_CYCLES(30)) u_fsc_flash_ctrl (.pclk(pclk),
    .presetn(presetn), .bus(sfr.dev), .flash_wr(flash_wr), .flash_addr(flash_addr),
    .flash_data(flash_data), .external_data_ram_wr(external_data_ram_wr), .external_data_ram_addr(external_data_ram_addr),
    .external_data_ram_data(external_data_ram_data), .page_erase_start(pg_go), .mass_erase_start(me_go),
    .erase_page(erase_page));
  fsc_flash_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn), .sfr_we(sfr.sfr_we),
    .sfr_re(sfr.sfr_re), .sfr_addr(sfr.sfr_addr), .sfr_wdata(sfr.sfr_wdata),
    .sfr_rdata(sfr.sfr_rdata), .debug_port_en(sfr.debug_port_en),
    .erase_busy(sfr.erase_busy));
  // ---------------------------------------------------------------
  // Clock and pulse counters
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (pg_go === 1'b1) n_pg++;
    if (me_go === 1'b1) n_me++;
    if (flash_wr === 1'b1) n_fl++;
    if (external_data_ram_wr === 1'b1) n_xr++;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      print_verdict;
    end
  endtask : apb
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, fsc_pkg::APB_SFR_WRITE, {16'h0000, a, d});
    repeat (3) @(posedge pclk);
  endtask : sfr_w
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b1, fsc_pkg::APB_SFR_READ, {16'h0000, a, 8'h00});
    repeat (2) @(posedge pclk);
    apb(1'b0, fsc_pkg::APB_SFR_READ, 32'h0);
    chk({rd[31], rd[7:0]}, {1'b1, exp});
  endtask : sfr_r
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, fsc_pkg::APB_STORE, {8'h00, a, d});
    repeat (3) @(posedge pclk);
  endtask : store
  task automatic ctrl(input logic irq, input logic dbg);
    apb(1'b1, fsc_pkg::APB_CTRL, {30'h0, dbg, irq});
  endtask : ctrl
  task automatic wait_idle;
    int i;
    for (i = 0; i < 60; i++)
    begin
      apb(1'b0, fsc_pkg::APB_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 60)
    begin
      chk(32'h1, 32'h0);
      print_verdict;
    end
  endtask : wait_idle
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    sfr_r(fsc_pkg::SFR_PERMIT, 8'h00);
    chk(erase_page, 7'h00);
    apb(1'b1, 8'h20, 32'h0);
    chk(er, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_page;
    ctrl(1'b0, 1'b0);
    sfr_w(fsc_pkg::SFR_PAGE_SELECT, 8'hfe);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h55);
    chk({n_pg[7:0], 1'b0, erase_page}, 16'h017f);
    sfr_w(fsc_pkg::SFR_PAGE_SELECT, 8'h02);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h55);
    chk(n_pg, 1);
    wait_idle;
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h55);
    chk({n_pg[7:0], 1'b0, erase_page}, 16'h0201);
    wait_idle;
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h55);
    chk(n_pg, 2);
    sfr_w(fsc_pkg::SFR_PAGE_SELECT, 8'h04);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h5a);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h00);
    chk({n_pg[7:0], n_me[7:0]}, 16'h0200);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h55);
    chk({n_pg[7:0], 1'b0, erase_page}, 16'h0302);
    wait_idle;
    $display("test page done");
  endtask : t_page
  task automatic t_mass;
    ctrl(1'b0, 1'b1);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'haa);
    chk(n_me, 0);
    ctrl(1'b0, 1'b0);
    sfr_w(fsc_pkg::SFR_PERMIT, 8'h02);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'haa);
    chk(n_me, 0);
    ctrl(1'b0, 1'b1);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'haa);
    chk(n_me, 1);
    wait_idle;
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'haa);
    chk(n_me, 1);
    $display("test mass done");
  endtask : t_mass
  task automatic t_store;
    store(16'h1234, 8'h5a);
    chk({n_xr[7:0], external_data_ram_addr, external_data_ram_data}, 32'h0112345a);
    sfr_w(fsc_pkg::SFR_PERMIT, 8'h01);
    sfr_r(fsc_pkg::SFR_PERMIT, 8'h01);
    store(16'habcd, 8'hc3);
    chk({n_fl[7:0], flash_addr, flash_data}, 32'h01abcdc3);
    sfr_r(fsc_pkg::SFR_PERMIT, 8'h00);
    store(16'h0042, 8'h99);
    chk({n_fl[7:0], n_xr[7:0]}, 16'h0102);
    ctrl(1'b1, 1'b1);
    apb(1'b0, fsc_pkg::APB_CTRL, 32'h0);
    chk(rd, 32'h0000_0003);
    sfr_w(fsc_pkg::SFR_PERMIT, 8'h01);
    sfr_r(fsc_pkg::SFR_PERMIT, 8'h00);
    ctrl(1'b0, 1'b1);
    sfr_w(fsc_pkg::SFR_PERMIT, 8'h01);
    ctrl(1'b1, 1'b1);
    sfr_w(fsc_pkg::SFR_PERMIT, 8'h00);
    sfr_r(fsc_pkg::SFR_PERMIT, 8'h01);
    sfr_w(fsc_pkg::SFR_PAGE_SELECT, 8'h06);
    sfr_w(fsc_pkg::SFR_ERASE_COMMAND, 8'h55);
    store(16'h0100, 8'h11);
    chk(n_fl, 1);
    wait_idle;
    $display("test store done");
  endtask : t_store
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_page;
    t_mass;
    t_store;
    print_verdict;
  end
endmodule : fsc_flash_ctrl_bench
